// *** complementary_waveform_core_tb.sv ***
// Self-checking testbench of the complementary waveform unit core
`include "cwu_defines.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end

module complementary_waveform_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk;
  logic rst_b;
  logic fast_osc_clk_en;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  cwu_pkg::cwu_pins_t pins;
  logic src_lvl;
  logic [3:0] src_sel;
  logic [3:0] fault_b;
  logic [15:0] mod_src;
  logic [3:0] shut_src_b;
  int n_errors;
  int checks_done;
  localparam logic [3:0] EXP_HI [5] = '{4'hF, 4'hF, 4'h9, 4'h6, 4'h5};
  localparam logic [3:0] EXP_LO [5] = '{4'h0, 4'h0, 4'h1, 4'h4, 4'hA};

  cwu_core u_dut (.clk(clk), .rst_b(rst_b), .fast_osc_clk_en(fast_osc_clk_en),
    .mod_src(mod_src), .shut_src_b(shut_src_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pins(pins));
  cwu_src_model u_src (.clk(clk), .lvl(src_lvl), .sel(src_sel), .fault_b(fault_b),
    .mod_src(mod_src), .shut_src_b(shut_src_b));

  //****************************************************************************
  // Bus and stimulus tasks
  //****************************************************************************
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e, input string nm);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    `CHK(nm, e, reg_rdata)
  endtask

  // Source model adds one edge before the three edges of the unit's own path
  task automatic drive(input logic l);
    @(posedge clk);
    src_lvl <= l;
    repeat (5) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic settle();
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic pin_chk(input logic [3:0] e, input string nm);
    `CHK(nm, e, pins.lvl)
  endtask

  // Disable first so every mode starts from a cleared sequencer
  task automatic set_mode(input logic [2:0] m);
    wr(`CWU_A_CTRL0, {5'h00, m});
    wr(`CWU_A_CTRL0, {5'h10, m});
  endtask

  task automatic finish_test();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  //****************************************************************************
  // Clock and watchdog
  //****************************************************************************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    repeat (50000) @(posedge clk);
    n_errors++;
    finish_test();
  end

  //****************************************************************************
  // Tests
  //****************************************************************************
  initial begin
    rst_b = 1'b0;
    fast_osc_clk_en = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    src_lvl = 1'b0;
    src_sel = 4'h0;
    fault_b = 4'hF;
    n_errors = 0;
    checks_done = 0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(`CWU_A_ISEL, `CWU_RST_8, "source select reset");
    wr(`CWU_A_ISEL, 8'hF5);
    rd_chk(`CWU_A_ISEL, 8'h05, "source select readback");
    rd_chk(4'hF, 8'h00, "unmapped read");
    wr(`CWU_A_CTRL1, 8'h0F);
    wr(`CWU_A_STEER, 8'hFF);
    wr(`CWU_A_DBR, 8'h00);
    wr(`CWU_A_DBF, 8'h00);
    wr(`CWU_A_SHUT, 8'h00);
    wr(`CWU_A_CLK, 8'h00);
    drive(1'b1);
    `CHK("pins while disabled", 8'h00, pins)
    set_mode(`CWU_M_HALF);
    for (int i = 0; i < 16; i++) begin
      wr(`CWU_A_ISEL, 8'(i));
      src_sel <= 4'(i);
      drive(1'b1);
      pin_chk(4'h5, "half bridge high");
      `CHK("enables", 4'hF, pins.oe)
      drive(1'b0);
      pin_chk(4'hA, "half bridge low");
    end
    for (int m = 0; m < 5; m++) begin
      set_mode(3'(m));
      drive(1'b1);
      pin_chk(EXP_HI[m], "mode high");
      drive(1'b0);
      pin_chk(EXP_LO[m], "mode low");
    end
    set_mode(`CWU_M_REV);
    wr(`CWU_A_CTRL0, 8'h82);
    drive(1'b1);
    pin_chk(4'h9, "direction flip");
    drive(1'b0);
    wr(`CWU_A_DBR, 8'h43);
    wr(`CWU_A_DBF, 8'h42);
    set_mode(`CWU_M_HALF);
    drive(1'b1);
    pin_chk(4'h0, "rise dead band");
    settle();
    pin_chk(4'h5, "rise dead band end");
    drive(1'b0);
    pin_chk(4'h0, "fall dead band");
    settle();
    pin_chk(4'hA, "fall dead band end");
    wr(`CWU_A_CTRL0, 8'h83);
    drive(1'b1);
    pin_chk(4'h4, "reverse dead band");
    settle();
    pin_chk(4'h6, "reverse dead band end");
    drive(1'b0);
    drive(1'b1);
    pin_chk(4'h6, "no repeat dead band");
    drive(1'b0);
    wr(`CWU_A_DBR, 8'h00);
    wr(`CWU_A_DBF, 8'h00);
    set_mode(`CWU_M_HALF);
    wr(`CWU_A_CTRL1, 8'h00);
    drive(1'b1);
    pin_chk(4'hA, "active low high");
    drive(1'b0);
    pin_chk(4'h5, "active low low");
    wr(`CWU_A_SHUT, 8'hB0);
    settle();
    pin_chk(4'hF, "software shutdown");
    rd_chk(`CWU_A_STAT, 8'h8F, "status in shutdown");
    wr(`CWU_A_SHUT, 8'h00);
    wr(`CWU_A_CTRL1, 8'h0F);
    wr(`CWU_A_SHUT, 8'h31);
    @(posedge clk);
    fault_b <= 4'hE;
    settle();
    pin_chk(4'hF, "external shutdown");
    drive(1'b1);
    drive(1'b0);
    pin_chk(4'hF, "shutdown held");
    @(posedge clk);
    fault_b <= 4'hF;
    wr(`CWU_A_SHUT, 8'h00);
    drive(1'b1);
    pin_chk(4'h5, "after shutdown");
    drive(1'b0);
    wr(`CWU_A_SHUT, 8'hF0);
    settle();
    pin_chk(4'hF, "restart held");
    drive(1'b1);
    pin_chk(4'h5, "auto restart");
    rd_chk(`CWU_A_SHUT, 8'h70, "restart cleared");
    drive(1'b0);
    wr(`CWU_A_SHUT, 8'h00);
    set_mode(`CWU_M_PUSH);
    drive(1'b1);
    pin_chk(4'h5, "push pull first");
    drive(1'b0);
    pin_chk(4'h0, "push pull gap");
    drive(1'b1);
    pin_chk(4'hA, "push pull second");
    drive(1'b0);
    wr(`CWU_A_SHUT, 8'hB0);
    wr(`CWU_A_SHUT, 8'h00);
    drive(1'b1);
    pin_chk(4'h5, "push pull restart");
    drive(1'b0);
    set_mode(`CWU_M_STEER_SYN);
    drive(1'b1);
    wr(`CWU_A_STEER, 8'hF3);
    settle();
    pin_chk(4'hF, "sync steer waits");
    drive(1'b0);
    drive(1'b1);
    pin_chk(4'h3, "sync steer applied");
    set_mode(`CWU_M_STEER_IMM);
    wr(`CWU_A_STEER, 8'h5F);
    settle();
    `CHK("output enables", 4'h5, pins.oe)
    `CHK("immediate steer", 4'h5, pins.lvl & pins.oe)
    wr(`CWU_A_STEER, 8'hFF);
    wr(`CWU_A_CLK, 8'h01);
    wr(`CWU_A_DBR, 8'h43);
    set_mode(`CWU_M_HALF);
    drive(1'b0);
    drive(1'b1);
    settle();
    pin_chk(4'h0, "oscillator idle");
    @(posedge clk);
    fast_osc_clk_en <= 1'b1;
    settle();
    settle();
    pin_chk(4'h5, "oscillator running");
    wr(`CWU_A_CLK, 8'h00);
    wr(`CWU_A_CTRL0, 8'h00);
    settle();
    `CHK("pins after disable", 8'h00, pins)
    finish_test();
  end
endmodule

// *** cwu_core.sv ***
// Complementary waveform unit core: modes, dead band, steering, shutdown, registers
//******************************************************************************
//******************************************************************************
//
// Chosen here: the address map and the plain strobed port.
`include "cwu_defines.svh"

module cwu_core (
  input wire logic clk, // System clock, 250 MHz
  input wire logic rst_b, // Asynchronous reset, active low
  input wire logic fast_osc_clk_en, // Tick of the internal fast oscillator
  input wire logic [15:0] mod_src, // Sixteen candidate modulation sources
  input wire logic [3:0] shut_src_b, // Shutdown sources, active low
  input wire logic [`CWU_ADDR_W-1:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [7:0] reg_rdata, // Read data, cycle after the strobe
  output cwu_pkg::cwu_pins_t pins // Output levels and enables, A in bit 0
);
  //****************************************************************************
  // Reset release
  //****************************************************************************
  logic rst_s1_q;
  logic rst_s2_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  wire rst_n = rst_s2_q;

  //****************************************************************************
  // Registers
  //****************************************************************************
  logic [7:0] ctrl0_q; // EN, LD, mode in [2:0]
  logic [7:0] ctrl1_q; // Polarity in [3:0]
  logic [7:0] clk_q; // Clock select in bit 0
  logic [7:0] input_source_select_q;
  logic [7:0] dbr_q; // Rise dead band [5:0], rise enable bit 6
  logic [7:0] dbf_q;
  logic [7:0] steer_q; // Steer bits [3:0], output enables [7:4]
  logic [7:0] shut_q; // Shutdown bit 7, restart 6, source mask [3:0], ovr lvl [5:4]
  logic [5:0] dbr_act_q;
  logic [5:0] dbf_act_q;
  logic [3:0] steer_act_q;
  logic [7:0] rdata_q;

  wire en = ctrl0_q[`CWU_B_EN];
  wire [2:0] mode = ctrl0_q[2:0];
  wire [3:0] pol = ctrl1_q[3:0];
  wire [3:0] oe_bits = steer_q[7:4];
  wire wr_c0 = reg_wr && reg_addr == `CWU_A_CTRL0;
  wire wr_c1 = reg_wr && reg_addr == `CWU_A_CTRL1;
  wire wr_ck = reg_wr && reg_addr == `CWU_A_CLK;
  wire wr_is = reg_wr && reg_addr == `CWU_A_ISEL;
  wire wr_dr = reg_wr && reg_addr == `CWU_A_DBR;
  wire wr_df = reg_wr && reg_addr == `CWU_A_DBF;
  wire wr_st = reg_wr && reg_addr == `CWU_A_STEER;
  wire wr_sh = reg_wr && reg_addr == `CWU_A_SHUT;

  //****************************************************************************
  // Generator clock tick and input path
  //****************************************************************************
  // The fast oscillator is taken as a tick so the block keeps one clock domain
  wire tick = clk_q[0] ? fast_osc_clk_en : 1'b1;
  wire sel_src = mod_src[input_source_select_q[3:0]];
  logic in_s1_q;
  logic in_s2_q;
  logic in_d_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_s1_q <= 1'b0;
      in_s2_q <= 1'b0;
      in_d_q <= 1'b0;
    end else begin
      in_s1_q <= sel_src;
      in_s2_q <= in_s1_q;
      in_d_q <= in_s2_q;
    end
  end
  wire data = in_s2_q;
  wire rise = data && !in_d_q;
  wire fall = !data && in_d_q;

  //****************************************************************************
  // Shutdown
  //****************************************************************************
  wire ext_shut = |(~shut_src_b & shut_q[3:0]);
  wire shut_act = en && (shut_q[`CWU_B_SHUT] || ext_shut);
  wire shut_clr = shut_q[`CWU_B_REN] && rise && !ext_shut;

  //****************************************************************************
  // Push-pull sequencer
  //****************************************************************************
  cwu_pkg::cwu_pp_t pp_q;
  cwu_pkg::cwu_pp_t pp_d;
  always_comb begin
    case (pp_q)
      cwu_pkg::CWU_PP_IDLE: pp_d = rise ? cwu_pkg::CWU_PP_A : cwu_pkg::CWU_PP_IDLE;
      cwu_pkg::CWU_PP_A: pp_d = rise ? cwu_pkg::CWU_PP_B : cwu_pkg::CWU_PP_A;
      cwu_pkg::CWU_PP_B: pp_d = rise ? cwu_pkg::CWU_PP_A : cwu_pkg::CWU_PP_B;
      default: pp_d = cwu_pkg::CWU_PP_IDLE;
    endcase
    if (!en || shut_act) begin
      pp_d = cwu_pkg::CWU_PP_IDLE;
    end
  end

  //****************************************************************************
  // Dead band
  //****************************************************************************
  // Half-bridge: rise delays A, fall delays B. Full-bridge: rise/reverse
  // delays B, fall/forward delays D, only on the first edge after a flip.
  logic [5:0] cnt_q;
  logic cnt_run_q;
  logic db_done_q;
  logic dir_q; // Last applied direction, 1 = reverse
  wire full = mode[2:1] == 2'b01;
  wire half = mode == `CWU_M_HALF;
  wire use_fall_half = half && fall && dbf_q[`CWU_B_DBFEN];
  wire use_rise_half = half && rise && dbr_q[`CWU_B_DBREN];
  wire flip_edge = full && rise && (mode[0] != dir_q);
  wire flip_db_en = mode[0] ? dbr_q[`CWU_B_DBREN] : dbf_q[`CWU_B_DBFEN];
  wire [5:0] db_lim = (half ? (data ? dbr_act_q : dbf_act_q)
                            : (mode[0] ? dbr_act_q : dbf_act_q));
  wire db_start = use_rise_half || use_fall_half || (flip_edge && flip_db_en);
  wire cnt_end = cnt_run_q && tick && cnt_q >= db_lim;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= `CWU_DB_ZERO;
      cnt_run_q <= 1'b0;
      db_done_q <= 1'b1;
      dir_q <= 1'b0;
    end else begin
      if (db_start) begin
        cnt_q <= `CWU_DB_ZERO;
        cnt_run_q <= 1'b1;
        db_done_q <= 1'b0;
      end else if (cnt_end) begin
        cnt_run_q <= 1'b0;
        db_done_q <= 1'b1;
      end else if (cnt_run_q && tick) begin
        cnt_q <= cnt_q + 6'h01;
      end
      if (half && (rise || fall) && !db_start) begin
        db_done_q <= 1'b1;
      end
      if (full && rise) begin
        dir_q <= mode[0];
      end
      if (!full && !half) begin
        cnt_run_q <= 1'b0;
        db_done_q <= 1'b1;
      end
    end
  end

  //****************************************************************************
  // Register writes and shadow loads
  //****************************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl0_q <= `CWU_RST_8;
      ctrl1_q <= `CWU_RST_8;
      clk_q <= `CWU_RST_8;
      input_source_select_q <= `CWU_RST_8;
      dbr_q <= `CWU_RST_8;
      dbf_q <= `CWU_RST_8;
      steer_q <= `CWU_RST_8;
      shut_q <= `CWU_RST_8;
      dbr_act_q <= `CWU_DB_ZERO;
      dbf_act_q <= `CWU_DB_ZERO;
      steer_act_q <= 4'h0;
      pp_q <= cwu_pkg::CWU_PP_IDLE;
    end else begin
      pp_q <= pp_d;
      if (wr_c0) begin
        ctrl0_q <= reg_wdata;
      end else if (fall) begin
        ctrl0_q[`CWU_B_LD] <= 1'b0;
      end
      if (wr_c1) begin
        ctrl1_q <= reg_wdata;
      end
      if (wr_ck) begin
        clk_q <= reg_wdata;
      end
      if (wr_is) begin
        input_source_select_q <= reg_wdata;
      end
      if (wr_dr) begin
        dbr_q <= reg_wdata;
      end
      if (wr_df) begin
        dbf_q <= reg_wdata;
      end
      if (wr_st) begin
        steer_q <= reg_wdata;
      end
      // Auto-restart clear loses to a same-cycle software set
      if (wr_sh) begin
        shut_q <= reg_wdata;
      end else if (shut_clr) begin
        shut_q[`CWU_B_SHUT] <= 1'b0;
      end
      if (!en || (ctrl0_q[`CWU_B_LD] && fall)) begin
        dbr_act_q <= dbr_q[5:0];
        dbf_act_q <= dbf_q[5:0];
      end
      if (mode == `CWU_M_STEER_SYN) begin
        if (rise) begin
          steer_act_q <= steer_q[3:0];
        end
      end else begin
        steer_act_q <= steer_q[3:0];
      end
    end
  end

  //****************************************************************************
  // Waveform selection
  //****************************************************************************
  // The edge cycle itself is gated: the registered done flag drops one clock late
  wire a_hb = data && (!dbr_q[`CWU_B_DBREN] || (db_done_q && !rise));
  wire b_hb = !data && (!dbf_q[`CWU_B_DBFEN] || (db_done_q && !fall));
  wire pa = data && pp_q == cwu_pkg::CWU_PP_A;
  wire pb = data && pp_q == cwu_pkg::CWU_PP_B;
  wire fb_hold = (flip_edge && flip_db_en) || !db_done_q;
  logic [3:0] act; // Active-high waveform before polarity
  always_comb begin
    case (mode)
      `CWU_M_HALF: act = {b_hb, a_hb, b_hb, a_hb};
      `CWU_M_PUSH: act = {pb, pa, pb, pa};
      `CWU_M_FWD: act = {data && !fb_hold, 1'b0, 1'b0, 1'b1};
      `CWU_M_REV: act = {1'b0, 1'b1, data && !fb_hold, 1'b0};
      `CWU_M_STEER_IMM,
      `CWU_M_STEER_SYN: act = steer_act_q & {4{data}};
      default: act = 4'h0;
    endcase
  end
  // Override levels bypass polarity; in steering only steered pins shut down
  wire [3:0] ovr = {shut_q[5], shut_q[4], shut_q[5], shut_q[4]};
  wire steer_mode = mode[2:1] == 2'b00;
  wire [3:0] shut_mask = steer_mode ? steer_act_q : 4'hf;
  wire [3:0] steer_fix = 4'h0; // Fixed level of unsteered pins
  logic [3:0] lvl;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lvl[i] = pol[i] ? act[i] : !act[i];
      if (steer_mode && !steer_act_q[i]) begin
        lvl[i] = steer_fix[i];
      end
      if (shut_act && shut_mask[i]) begin
        lvl[i] = ovr[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pins <= '0;
    end else begin
      pins.lvl <= en ? lvl : 4'h0;
      pins.oe <= en ? oe_bits : 4'h0;
    end
  end

  //****************************************************************************
  // Register reads
  //****************************************************************************
  wire [7:0] stat = {shut_act, 3'h0, pins.lvl};
  logic [7:0] rmux;
  always_comb begin
    case (reg_addr)
      `CWU_A_CTRL0: rmux = ctrl0_q;
      `CWU_A_CTRL1: rmux = ctrl1_q;
      `CWU_A_CLK: rmux = clk_q;
      `CWU_A_ISEL: rmux = {4'h0, input_source_select_q[3:0]};
      `CWU_A_DBR: rmux = dbr_q;
      `CWU_A_DBF: rmux = dbf_q;
      `CWU_A_STEER: rmux = steer_q;
      `CWU_A_SHUT: rmux = shut_q;
      `CWU_A_STAT: rmux = stat;
      default: rmux = `CWU_RST_8;
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= `CWU_RST_8;
    end else begin
      rdata_q <= reg_rd ? rmux : `CWU_RST_8;
    end
  end
  assign reg_rdata = rdata_q;

  //****************************************************************************
  // Assertions
  //****************************************************************************
  a_disabled_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    !$past(en) |-> pins.oe == 4'h0 && pins.lvl == 4'h0)
    else $error("outputs active while disabled");
  a_pp_reset: assert property (@(posedge clk) disable iff (!rst_n)
    (!en || shut_act) |=> pp_q == cwu_pkg::CWU_PP_IDLE)
    else $error("push-pull not reset");
  a_pp_first_a: assert property (@(posedge clk) disable iff (!rst_n)
    (pp_q == cwu_pkg::CWU_PP_IDLE && rise && en && !shut_act) |=> pp_q == cwu_pkg::CWU_PP_A)
    else $error("first pulse not on A");
  a_fwd_static: assert property (@(posedge clk) disable iff (!rst_n)
    (mode == `CWU_M_FWD && en && !shut_act && pol == 4'hf) |=> pins.lvl[2:0] == 3'b001)
    else $error("forward static levels wrong");
  a_rev_static: assert property (@(posedge clk) disable iff (!rst_n)
    (mode == `CWU_M_REV && en && !shut_act && pol == 4'hf) |=> pins.lvl[3] == 1'b0 &&
    pins.lvl[2] == 1'b1 && pins.lvl[0] == 1'b0)
    else $error("reverse static levels wrong");
  a_sync_steer: assert property (@(posedge clk) disable iff (!rst_n)
    (mode == `CWU_M_STEER_SYN && !rise) |=> $stable(steer_act_q))
    else $error("steering changed without edge");
  a_imm_steer: assert property (@(posedge clk) disable iff (!rst_n)
    (mode == `CWU_M_STEER_IMM && wr_st) |=> ##1 steer_act_q == $past(reg_wdata[3:0], 2))
    else $error("immediate steering late");
  a_shut_ovr: assert property (@(posedge clk) disable iff (!rst_n)
    (shut_act && !steer_mode) |=> pins.lvl == $past(ovr))
    else $error("shutdown override missing");
  a_oe_follow: assert property (@(posedge clk) disable iff (!rst_n)
    en |=> pins.oe == $past(oe_bits))
    else $error("output enable mismatch");
  a_db_rise_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (half && en && !shut_act && pol == 4'hf && dbr_q[`CWU_B_DBREN] && rise) |=>
    !pins.lvl[0])
    else $error("rising dead band not held");
  a_flip_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (flip_edge && flip_db_en && en && !shut_act && pol == 4'hf) |=>
    !pins.lvl[1] && !pins.lvl[3])
    else $error("modulated leg active on direction change");
  a_restart_clr: assert property (@(posedge clk) disable iff (!rst_n)
    (shut_clr && !wr_sh) |=> !shut_q[`CWU_B_SHUT])
    else $error("auto restart did not clear shutdown");
  c_restart: cover property (@(posedge clk) shut_clr && shut_q[`CWU_B_SHUT]);
  c_push_pull: cover property (@(posedge clk) pp_q == cwu_pkg::CWU_PP_A ##[1:200]
    pp_q == cwu_pkg::CWU_PP_B);
  c_dir_flip: cover property (@(posedge clk) flip_edge);
  c_shutdown: cover property (@(posedge clk) shut_act && en);
  c_db_run: cover property (@(posedge clk) cnt_end);
endmodule

// *** cwu_defines.svh ***
// Register offsets, field positions and timing constants of the complementary waveform unit
`ifndef CWU_DEFINES_SVH
`define CWU_DEFINES_SVH

`define CWU_ADDR_W 4
`define CWU_A_CTRL0 4'h0
`define CWU_A_CTRL1 4'h1
`define CWU_A_CLK 4'h2
`define CWU_A_ISEL 4'h3
`define CWU_A_DBR 4'h4
`define CWU_A_DBF 4'h5
`define CWU_A_STEER 4'h6
`define CWU_A_SHUT 4'h7
`define CWU_A_STAT 4'h8

`define CWU_M_STEER_IMM 3'h0
`define CWU_M_STEER_SYN 3'h1
`define CWU_M_FWD 3'h2
`define CWU_M_REV 3'h3
`define CWU_M_HALF 3'h4
`define CWU_M_PUSH 3'h5

`define CWU_B_EN 7
`define CWU_B_LD 6
`define CWU_B_SHUT 7
`define CWU_B_REN 6
`define CWU_B_DBREN 6
`define CWU_B_DBFEN 6

`define CWU_FAST_OSC_MHZ 16
`define CWU_DB_ZERO 6'h00
`define CWU_RST_8 8'h00

`endif

// *** cwu_pkg.sv ***
// Types shared by the complementary waveform unit
package cwu_pkg;
  typedef struct packed {
    logic [3:0] lvl;
    logic [3:0] oe;
  } cwu_pins_t;

  typedef enum logic [2:0] {
    CWU_PP_IDLE = 3'b001,
    CWU_PP_A = 3'b010,
    CWU_PP_B = 3'b100
  } cwu_pp_t;
endpackage

// *** cwu_src_model.sv ***
// Behavioural model of the modulation sources and fault lines that feed the unit
module cwu_src_model (
  input wire logic clk, // Rising-edge clock
  input wire logic lvl, // Level of the selected source
  input wire logic [3:0] sel, // Index of the selected source
  input wire logic [3:0] fault_b, // Fault lines, active low
  output logic [15:0] mod_src, // Source bus into the unit
  output logic [3:0] shut_src_b // Shutdown lines, active low
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    mod_src = 16'hFFFE;
    shut_src_b = 4'hF;
  end
  // Unselected sources carry the inverse level, so a wrong selection shows at the pins
  always @(posedge clk) begin
    mod_src <= lvl ? (16'h0001 << sel) : ~(16'h0001 << sel);
    shut_src_b <= fault_b;
  end
endmodule
